// ---- adc_ctrl_pkg.sv ----
// package: register map, field positions and timing for the converter control block
package adc_ctrl_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CHAN = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'hC;
  // result registers sit in the small memory, one word per channel, from this base
  localparam logic [6:0] OFF_RES_BASE = 7'h40;
  // control register fields
  localparam int CTRL_PU_BIT = 7;
  localparam int CTRL_RES10_BIT = 6;
  localparam int CTRL_RJUST_BIT = 5;
  localparam int CTRL_SIGNED_BIT = 4;
  localparam int CTRL_CONT_BIT = 3;
  localparam int CTRL_IE_BIT = 2;
  localparam int CTRL_START_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hFC;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ABORT_BIT = 1;
  localparam int STAT_BUSY_BIT = 7;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_HZ = 2_000_000;
  localparam int CONV_DIV = CLK_HZ / CONV_HZ;
  localparam int CONV_TIME_NS = 14_000;
  // conversion clock cycles for a 10-bit conversion, rounded down as a longest time
  localparam int CONV_CYC_10 = CONV_TIME_NS / (1_000_000_000 / CONV_HZ);
  localparam int CONV_CYC_8 = CONV_CYC_10 - 2;
  localparam int CHANNELS = 8;
  typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;
endpackage

// ---- result_mem.sv ----
// small result memory: one word per channel, registered read data
`timescale 1ns/1ns
`default_nettype none
module result_mem (
  input wire logic clock,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [2:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [0:7];
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule
`default_nettype wire

// ---- adc_power_and_mode_control.sv ----
// converter control: power states, conversion sequencing, register slave
//
// Overview of operation
// - in stop mode the conversion clock is halted and the analog block is switched off.
// - entering stop abandons any one-shot or continuous conversion in progress.
// - leaving stop starts no conversion by itself and every register keeps its value.
// - if the power-up bit was set before stop, the converter is active again once stop ends.
// - clearing the power-up bit gates the conversion clock and turns the analog block off.
// - entering power-down abandons any conversion in progress.
// - writing the power-up bit to one brings the converter back to its active state.
// - in power-down all registers stay readable and writable.
// - the power-up bit resets to zero so the converter leaves reset powered down.
// - software selects one-shot or continuous conversion.
// - a finished conversion sets a completion flag and can raise an interrupt.
// - an input multiplexer selects one of eight channels as sample source.
// - results are 8 or 10 bits, left or right justified, or left justified signed.
// - a 10-bit conversion completes within 14 us at a 2 MHz conversion clock.
//
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module adc_power_and_mode_control (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic stop_mode,
  input wire logic sar_compare,
  output logic sar_analog_on,
  output logic sar_conv_clk_en,
  output logic sar_sample,
  output logic [2:0] sar_channel,
  output logic [9:0] sar_trial,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and bus decode
  logic [7:0] ctrl_q, ctrl_d;
  logic [2:0] chan_q;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q;
  logic rd_phase_q;
  logic [31:0] readdata_q;
  adc_ctrl_pkg::state_t state_q, state_d;
  logic [3:0] div_q;
  logic [3:0] bit_q;
  logic [9:0] sar_q;
  logic start_req;
  logic tick;
  logic active;
  logic conv_end;
  logic abort_now;
  logic [15:0] fmt_word;
  logic [15:0] mem_rdata;

  wire wr_ctrl = write && (address == {3'h0, adc_ctrl_pkg::OFF_CTRL});
  wire wr_chan = write && (address == {3'h0, adc_ctrl_pkg::OFF_CHAN});
  wire wr_mask = write && (address == {3'h0, adc_ctrl_pkg::OFF_MASK});
  wire rd_stat = read && !rd_phase_q && (address == {3'h0, adc_ctrl_pkg::OFF_STAT});
  wire is_res = address[6] && (address[5] == 1'b0) && (address[1:0] == 2'b00);
  wire pu = ctrl_q[adc_ctrl_pkg::CTRL_PU_BIT];
  wire res10 = ctrl_q[adc_ctrl_pkg::CTRL_RES10_BIT];
  wire cont = ctrl_q[adc_ctrl_pkg::CTRL_CONT_BIT];
  wire busy = (state_q == adc_ctrl_pkg::ST_SAMPLE) || (state_q == adc_ctrl_pkg::ST_CONVERT);

  // reads take two cycles so the result memory output is registered; writes take one
  assign waitrequest = read && !rd_phase_q;
  // result words come straight from the memory's output register in the answering cycle
  assign readdata = (rd_phase_q && is_res) ? {16'h0000, mem_rdata} : readdata_q;

  // registers stay accessible in every power state; neither stop nor power-down clears them
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= adc_ctrl_pkg::CTRL_RESET;
      chan_q <= 3'h0;
      mask_q <= adc_ctrl_pkg::MASK_RESET[1:0];
      rd_phase_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_chan) begin
        chan_q <= writedata[2:0];
      end
      if (wr_mask) begin
        mask_q <= writedata[1:0];
      end
      rd_phase_q <= read && !rd_phase_q;
    end
  end

  // start bit self-clears; a write with start set launches a conversion
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = writedata[7:0] & adc_ctrl_pkg::CTRL_WMASK;
    end
  end
  assign start_req = wr_ctrl && writedata[adc_ctrl_pkg::CTRL_START_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // power state
  // stop mode overrides the power-up bit but never touches it, so the bit brings it back
  assign active = pu && !stop_mode;
  assign sar_analog_on = active;
  assign abort_now = busy && !active;

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock divider, gated off when inactive
  assign tick = active && (div_q == 4'(adc_ctrl_pkg::CONV_DIV - 1));
  assign sar_conv_clk_en = active && busy;

  always_ff @(posedge clock) begin
    if (!nrst || !active) begin
      div_q <= 4'h0;
    end else if (tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // successive approximation sequencer
  // sample for two conversion clocks then one bit per conversion clock
  // 8-bit conversions resolve the upper bits only, so they stop two bits early
  function automatic logic [3:0] last_bit(input logic r10);
    last_bit = r10 ? 4'd0 : 4'd2;
  endfunction

  assign conv_end = tick && (state_q == adc_ctrl_pkg::ST_CONVERT) && (bit_q == last_bit(res10));

  always_comb begin
    state_d = state_q;
    case (state_q)
      adc_ctrl_pkg::ST_OFF: begin
        if (active) begin
          state_d = adc_ctrl_pkg::ST_IDLE; // no conversion starts by itself
        end
      end
      adc_ctrl_pkg::ST_IDLE: begin
        if (!active) begin
          state_d = adc_ctrl_pkg::ST_OFF;
        end else if (start_req) begin
          state_d = adc_ctrl_pkg::ST_SAMPLE;
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (!active) begin
          state_d = adc_ctrl_pkg::ST_OFF;
        end else if (tick && bit_q == 4'h0) begin
          state_d = adc_ctrl_pkg::ST_CONVERT;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (!active) begin
          state_d = adc_ctrl_pkg::ST_OFF;
        end else if (conv_end) begin
          state_d = cont ? adc_ctrl_pkg::ST_SAMPLE : adc_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = adc_ctrl_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= adc_ctrl_pkg::ST_OFF;
      bit_q <= 4'h0;
      sar_q <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_q != adc_ctrl_pkg::ST_SAMPLE && state_d == adc_ctrl_pkg::ST_SAMPLE) begin
        bit_q <= 4'h1;
      end else if (state_q == adc_ctrl_pkg::ST_SAMPLE && state_d == adc_ctrl_pkg::ST_CONVERT) begin
        bit_q <= 4'd9;
        sar_q <= 10'h000;
      end else if (tick && bit_q != 4'h0) begin
        bit_q <= bit_q - 4'h1;
      end
      if (tick && state_q == adc_ctrl_pkg::ST_CONVERT) begin
        sar_q <= sar_q | ({9'h000, sar_compare} << bit_q);
      end
    end
  end

  assign sar_sample = (state_q == adc_ctrl_pkg::ST_SAMPLE);
  assign sar_channel = chan_q;
  assign sar_trial = sar_q | ((state_q == adc_ctrl_pkg::ST_CONVERT) ? (10'h001 << bit_q) : 10'h000);

  ////////////////////////////////////////////////////////////////////////////
  // result formatting and storage
  // 8-bit results use only the upper bits of the sar word
  function automatic logic [15:0] format(input logic [9:0] v, input logic r10, input logic rj, input logic sg);
    logic [9:0] m;
    m = r10 ? v : {2'b00, v[9:2]};
    if (sg) begin
      format = r10 ? {~v[9], v[8:0], 6'h00} : {~v[9], v[8:2], 8'h00};
    end else if (rj) begin
      format = {6'h00, m};
    end else begin
      format = r10 ? {v, 6'h00} : {v[9:2], 8'h00};
    end
  endfunction
  assign fmt_word = format(sar_q | ({9'h000, sar_compare} << bit_q), res10, ctrl_q[adc_ctrl_pkg::CTRL_RJUST_BIT],
                           ctrl_q[adc_ctrl_pkg::CTRL_SIGNED_BIT]);

  result_mem u_mem (
    .clock(clock),
    .we(conv_end),
    .waddr(chan_q),
    .wdata(fmt_word),
    .raddr(address[4:2]),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status, interrupt, read data
  // set beats the clearing read in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (rd_stat) begin
      stat_d = 2'b00;
    end
    if (conv_end) begin
      stat_d[adc_ctrl_pkg::STAT_DONE_BIT] = 1'b1;
    end
    if (abort_now) begin
      stat_d[adc_ctrl_pkg::STAT_ABORT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stat_q <= 2'b00;
      readdata_q <= 32'h0000_0000;
    end else begin
      stat_q <= stat_d;
      if (read && !rd_phase_q) begin
        case (address)
          {3'h0, adc_ctrl_pkg::OFF_CTRL}: readdata_q <= {24'h00_0000, ctrl_q};
          {3'h0, adc_ctrl_pkg::OFF_CHAN}: readdata_q <= {29'h0, chan_q};
          {3'h0, adc_ctrl_pkg::OFF_STAT}: readdata_q <= {24'h00_0000, busy, 5'h00, stat_q};
          {3'h0, adc_ctrl_pkg::OFF_MASK}: readdata_q <= {30'h0, mask_q};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // interrupt only when software chose interrupt signalling
  assign irq = ctrl_q[adc_ctrl_pkg::CTRL_IE_BIT] && |(stat_q & mask_q);
endmodule
`default_nettype wire

// ---- adc_ctrl_props.sv ----
// assertion checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_props (
  input wire logic clock, nrst, read, write, waitrequest, stop_mode,
  input wire logic [6:0] address,
  input wire logic [31:0] writedata,
  input wire logic sar_analog_on, sar_conv_clk_en, sar_sample, irq,
  input wire logic [2:0] sar_channel
);
  logic pu_q, ie_q, smp_q;
  logic [9:0] cyc_q;
  wire ctrl_wr = write && address == {3'h0, adc_ctrl_pkg::OFF_CTRL};
  wire chan_wr = write && address == {3'h0, adc_ctrl_pkg::OFF_CHAN};
  wire busy = sar_conv_clk_en || sar_sample;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pu_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (ctrl_wr) begin
      pu_q <= writedata[adc_ctrl_pkg::CTRL_PU_BIT];
      ie_q <= writedata[adc_ctrl_pkg::CTRL_IE_BIT];
    end
  end
  // restart at each sample phase, so continuous mode is timed per result
  always_ff @(posedge clock) begin
    smp_q <= sar_sample;
    cyc_q <= (!nrst || !busy || (sar_sample && !smp_q)) ? 10'h000 : cyc_q + 10'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence quiet;
    !sar_conv_clk_en && !sar_sample;
  endsequence
  sequence rd_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  AST_ANALOG: assert property (sar_analog_on == (pu_q && !stop_mode))
    else $error("analog enable does not follow power-up bit and stop");
  AST_STOP: assert property (stop_mode [*2] |-> quiet)
    else $error("conversion activity during stop");
  AST_PD: assert property (!sar_analog_on && !$past(sar_analog_on) |-> quiet)
    else $error("conversion activity while powered down");
  AST_EXIT: assert property ($fell(stop_mode) |-> quiet [*4])
    else $error("conversion began on its own after stop");
  AST_RD: assert property ($rose(read) |-> rd_wait)
    else $error("read handshake timing wrong");
  AST_WR: assert property (write |-> !waitrequest)
    else $error("write was stalled");
  AST_CHAN: assert property (chan_wr |=> sar_channel == $past(writedata[2:0]))
    else $error("channel select does not follow write");
  AST_TIME: assert property (cyc_q < 10'h118)
    else $error("conversion longer than 280 clocks");
  AST_IRQ: assert property (irq |-> ie_q)
    else $error("interrupt without enable");
endmodule
bind adc_power_and_mode_control adc_ctrl_props chk (.clock(clock), .nrst(nrst), .read(read), .write(write),
  .waitrequest(waitrequest), .stop_mode(stop_mode), .address(address), .writedata(writedata),
  .sar_analog_on(sar_analog_on), .sar_conv_clk_en(sar_conv_clk_en), .sar_sample(sar_sample), .irq(irq),
  .sar_channel(sar_channel));
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [6:0] A_CTRL = {3'h0, adc_ctrl_pkg::OFF_CTRL};
  localparam logic [6:0] A_CHAN = {3'h0, adc_ctrl_pkg::OFF_CHAN};
  localparam logic [6:0] A_STAT = {3'h0, adc_ctrl_pkg::OFF_STAT};
  localparam logic [6:0] A_MASK = {3'h0, adc_ctrl_pkg::OFF_MASK};
  logic clock = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, stop_mode = 1'b0, sar_compare = 1'b0;
  logic [6:0] address = 7'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, st;
  logic waitrequest, sar_analog_on, sar_conv_clk_en, sar_sample, irq;
  logic [2:0] sar_channel;
  logic [9:0] sar_trial, ain = 10'h000;
  int mismatches = 0, checks_done = 0, cycles = 0, seed = 38;
  int res_m[8];
  always #25 clock = ~clock;
  // analog input at or above the trial code keeps the bit
  always @(posedge clock) sar_compare <= ain >= sar_trial;
  adc_power_and_mode_control uut (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .stop_mode(stop_mode),
    .sar_compare(sar_compare), .sar_analog_on(sar_analog_on), .sar_conv_clk_en(sar_conv_clk_en),
    .sar_sample(sar_sample), .sar_channel(sar_channel), .sar_trial(sar_trial), .irq(irq));
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [6:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [6:0] a);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    st = readdata;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task rc(input string name, input logic [6:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, exp, st);
  endtask
  // one-shot conversion on a random channel, with resolution, justification and sign taken from c
  task conv(input int m, input logic [7:0] c);
    int ch, t0, v, sh;
    ch = $random(seed) & 7;
    ain = 10'($random(seed));
    v = c[6] ? int'(ain) : int'(ain) >> 2;
    sh = c[6] ? 6 : 8;
    if (c[4])
      res_m[ch] = (v << sh) ^ 32'h0000_8000;
    else if (c[5])
      res_m[ch] = v;
    else
      res_m[ch] = v << sh;
    wr(A_CHAN, 32'(ch));
    chk("channel", 32'(ch), 32'(sar_channel));
    wr(A_MASK, 32'(m));
    wr(A_CTRL, 32'(c));
    t0 = cycles;
    st = 32'h0000_0000;
    if (m != 0)
      while (irq !== 1'b1) @(posedge clock);
    else
      while (st[0] !== 1'b1) rd(A_STAT);
    chk("conv_in_time", 32'h0000_0001, 32'(cycles - t0 <= 285));
    if (m != 0) begin
      rc("stat_done", A_STAT, 32'h0000_0001);
      chk("irq_cleared", 32'h0000_0000, 32'(irq));
    end else begin
      chk("stat_done", 32'h0000_0001, st);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
    end
    rc("result", adc_ctrl_pkg::OFF_RES_BASE + 7'(ch * 4), res_m[ch]);
    repeat (300) @(posedge clock);
    rc("oneshot_idle", A_STAT, 32'h0000_0000);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 5; i++) rc("reset_value", 7'(i * 4), 32'h0000_0000);
    chk("analog_on", 32'h0000_0000, 32'(sar_analog_on));
    wr(7'h10, 32'hFFFF_FFFF);
    rc("unmapped", 7'h10, 32'h0000_0000);
    wr(A_MASK, 32'h0000_0003);
    rc("mask_pd", A_MASK, 32'h0000_0003);
    wr(A_CHAN, 32'h0000_0005);
    rc("chan_pd", A_CHAN, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_0080);
    chk("analog_on", 32'h0000_0001, 32'(sar_analog_on));
    conv(0, 8'hE5);
    conv(1, 8'hA5);
    conv(0, 8'hC5);
    conv(1, 8'h95);
    // abort by stop in mid-conversion
    wr(A_MASK, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_00E5);
    repeat (40) @(posedge clock);
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk("stop_analog", 32'h0000_0000, 32'(sar_analog_on));
    chk("stop_clk", 32'h0000_0000, 32'(sar_conv_clk_en));
    repeat (20) @(posedge clock);
    stop_mode <= 1'b0;
    repeat (5) @(posedge clock);
    chk("exit_analog", 32'h0000_0001, 32'(sar_analog_on));
    chk("exit_idle", 32'h0000_0000, 32'(sar_conv_clk_en | sar_sample));
    rc("ctrl_kept", A_CTRL, 32'h0000_00E4);
    chk("abort_irq", 32'h0000_0001, 32'(irq));
    rc("stat_abort", A_STAT, 32'h0000_0002);
    // power-down in mid continuous sequence
    wr(A_MASK, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_00ED);
    repeat (150) @(posedge clock);
    wr(A_CTRL, 32'h0000_006C);
    repeat (2) @(posedge clock);
    chk("pd_analog", 32'h0000_0000, 32'(sar_analog_on));
    chk("pd_clk", 32'h0000_0000, 32'(sar_conv_clk_en));
    rc("stat_pd", A_STAT, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_00EC);
    wr(A_CTRL, 32'h0000_00ED);
    repeat (150) @(posedge clock);
    rd(A_STAT);
    repeat (150) @(posedge clock);
    rd(A_STAT);
    chk("cont_again", 32'h0000_0001, 32'(st[0]));
    tally_and_finish;
  end
endmodule
`default_nettype wire
